// ==== rtl/sfrb_pkg.sv ====
// Shared constants, types and helpers for the serial flash read and buffer command link
package sfrb_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_LP_ARRAY_READ = 8'h01;
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;
  localparam logic [7:0] OP_BUF1_READ_HF = 8'hD4;
  localparam logic [7:0] OP_BUF1_READ_LF = 8'hD1;
  localparam logic [7:0] OP_BUF2_READ_HF = 8'hD6;
  localparam logic [7:0] OP_BUF2_READ_LF = 8'hD3;
  localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_BUF1_PROG_ERASE = 8'h83;
  localparam logic [7:0] OP_BUF2_PROG_ERASE = 8'h86;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int PAGE_COUNT = 4096;
  localparam int STD_PAGE_BYTES = 528;
  localparam int BIN_PAGE_BYTES = 512;
  localparam int ARRAY_BYTES = PAGE_COUNT * STD_PAGE_BYTES;
  localparam int ARRAY_AW = 22;
  localparam logic [9:0] STD_LAST_COL = 10'h20F;
  localparam logic [9:0] BIN_LAST_COL = 10'h1FF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [3:0] OPCODE_IDX = 4'h0;
  localparam logic [3:0] LAST_ADDR_IDX = 4'h3;
  localparam logic [3:0] FIRST_DATA_IDX = 4'h4;
  localparam logic [3:0] PAGE_READ_DUMMY = 4'h4;
  localparam logic [3:0] BUF_READ_HF_DUMMY = 4'h1;

  // ----------------------------------------
  // Host link clock divider: half period in system clock cycles
  // ----------------------------------------
  localparam logic [3:0] SCK_HALF_CYCLES = 4'h8;

  typedef enum logic [3:0] {
    SFRB_PE_IDLE = 4'b0001,
    SFRB_PE_ERASE = 4'b0010,
    SFRB_PE_WRITE = 4'b0100,
    SFRB_PE_VERIFY = 4'b1000
  } sfrb_pe_t;

  typedef enum logic [2:0] {
    SFRB_H_IDLE = 3'b001,
    SFRB_H_SHIFT = 3'b010,
    SFRB_H_GAP = 3'b100
  } sfrb_host_t;

  function automatic logic [3:0] sfrb_dummy_bytes(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    if (op == OP_PAGE_READ) begin
      n = PAGE_READ_DUMMY;
    end else if (op == OP_BUF1_READ_HF || op == OP_BUF2_READ_HF) begin
      n = BUF_READ_HF_DUMMY;
    end
    return n;
  endfunction

  function automatic logic sfrb_is_read(input logic [7:0] op);
    return op == OP_LP_ARRAY_READ || op == OP_PAGE_READ || op == OP_BUF1_READ_HF ||
           op == OP_BUF1_READ_LF || op == OP_BUF2_READ_HF || op == OP_BUF2_READ_LF;
  endfunction

  function automatic logic sfrb_is_buf_read(input logic [7:0] op);
    return op == OP_BUF1_READ_HF || op == OP_BUF1_READ_LF ||
           op == OP_BUF2_READ_HF || op == OP_BUF2_READ_LF;
  endfunction

  function automatic logic sfrb_is_write(input logic [7:0] op);
    return op == OP_BUF1_WRITE || op == OP_BUF2_WRITE;
  endfunction

  function automatic logic sfrb_is_prog(input logic [7:0] op);
    return op == OP_BUF1_PROG_ERASE || op == OP_BUF2_PROG_ERASE;
  endfunction

  // Buffer 2 opcodes
  function automatic logic sfrb_buf_sel(input logic [7:0] op);
    return op == OP_BUF2_READ_HF || op == OP_BUF2_READ_LF || op == OP_BUF2_WRITE || op == OP_BUF2_PROG_ERASE;
  endfunction

endpackage

// ==== rtl/sfrb_link_if.sv ====
// Serial link between the flash device end and the host master end
`timescale 1ns/10ps
`default_nettype none
interface sfrb_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic so_line;

  // Serial output line floats high through a pull-up when the device lets go
  assign so_line = so_oe_n ? 1'b1 : so;

  modport dev (
    input sck,
    input cs_n,
    input si,
    output so,
    output so_oe_n
  );

  modport host (
    output sck,
    output cs_n,
    output si,
    input so_line
  );
endinterface
`default_nettype wire

// ==== rtl/sfrb_device.sv ====
// Flash device end: command decode, array and buffer storage, program engine
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - 01h plus three address bytes, no dummy
// - 528 mode: 12 page, 10 byte bits
// - 512 mode: 12 page, 9 byte bits
// - Continuous read rolls into next page
// - Continuous read wraps array end to start
// - Chip select stays low whole command
// - Select rising ends read, output released
// - Array reads leave buffers untouched
// - D2h: address, four dummy bytes, data
// - Page read wraps within same page
// - Buffer read opcodes D4h/D1h, D6h/D3h
// - Buffer address: don't-care bits, offset
// - Fast buffer read needs one dummy
// - Buffer read wraps to buffer start
// - Buffer write 84h/87h, offset starts
// - Write bytes stored, wrap, until select
// - Program erase 83h/86h with page address
// - Select rising erases page, writes buffer
// - Busy flag while self-timed program
// - Failed byte sets error flag
module sfrb_device (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PAGE_BIN,
  output logic BUSY,
  output logic ERASE_PROGRAM_ERROR_FLAG,
  sfrb_link_if.dev LINK
);

  // ----------------------------------------
  // Link synchronisers
  // ----------------------------------------
  logic sck_s1, sck_s2, sck_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic si_s1, si_s2;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
    end else begin
      sck_s1 <= LINK.sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1 <= LINK.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      si_s1 <= LINK.si;
      si_s2 <= si_s1;
    end
  end

  logic sel;
  logic sck_rise, sck_fall, cs_rise;
  assign sel = !cs_s2;
  assign sck_rise = sel && sck_s2 && !sck_s3;
  assign sck_fall = sel && !sck_s2 && sck_s3;
  assign cs_rise = cs_s2 && !cs_s3;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  localparam int ARRAY_BYTES_L = sfrb_pkg::ARRAY_BYTES;
  localparam int ARRAY_AW_L = sfrb_pkg::ARRAY_AW;
  logic [7:0] main_mem [ARRAY_BYTES_L];
  logic [7:0] buf_mem [2][sfrb_pkg::STD_PAGE_BYTES];

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  logic [2:0] bit_cnt;
  logic [7:0] in_sh;
  logic [3:0] byte_idx;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [11:0] page;
  logic [9:0] col;
  logic [9:0] buf_ptr;
  logic [7:0] next_byte;
  logic [23:0] next_addr;
  logic [9:0] last_col;
  logic data_phase;
  logic byte_done;

  assign next_byte = {in_sh[6:0], si_s2};
  assign next_addr = {addr[15:0], next_byte};
  assign last_col = PAGE_BIN ? sfrb_pkg::BIN_LAST_COL : sfrb_pkg::STD_LAST_COL;
  assign byte_done = sck_rise && bit_cnt == 3'h7;
  assign data_phase = sfrb_pkg::sfrb_is_read(opcode) && (byte_idx >= sfrb_pkg::FIRST_DATA_IDX +
                      sfrb_pkg::sfrb_dummy_bytes(opcode));

  // Bit and byte counters restart with every select low period
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt <= 3'h0;
      in_sh <= 8'h00;
      byte_idx <= 4'h0;
    end else if (!sel) begin
      bit_cnt <= 3'h0;
      byte_idx <= 4'h0;
    end else if (sck_rise) begin
      in_sh <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      // Saturate so long data streams keep the count in the data region
      if (bit_cnt == 3'h7 && byte_idx != 4'hF) begin
        byte_idx <= byte_idx + 4'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      opcode <= 8'h00;
      addr <= 24'h000000;
    end else if (byte_done && byte_idx == sfrb_pkg::OPCODE_IDX) begin
      opcode <= next_byte;
    end else if (byte_done && byte_idx <= sfrb_pkg::LAST_ADDR_IDX) begin
      addr <= next_addr;
    end
  end

  // ----------------------------------------
  // Read and write pointers
  // ----------------------------------------
  logic load_out;
  assign load_out = sck_fall && bit_cnt == 3'h0 && data_phase;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      page <= 12'h000;
      col <= 10'h000;
      buf_ptr <= 10'h000;
    end else if (byte_done && byte_idx == sfrb_pkg::LAST_ADDR_IDX) begin
      if (PAGE_BIN) begin
        page <= next_addr[20:9];
        col <= {1'b0, next_addr[8:0]};
        buf_ptr <= {1'b0, next_addr[8:0]};
      end else begin
        page <= next_addr[21:10];
        col <= next_addr[9:0];
        buf_ptr <= next_addr[9:0];
      end
    end else if (load_out && sfrb_pkg::sfrb_is_buf_read(opcode)) begin
      buf_ptr <= (buf_ptr >= last_col) ? 10'h000 : buf_ptr + 10'h001;
    end else if (load_out) begin
      if (col >= last_col) begin
        col <= 10'h000;
        // Page read stays on its page; continuous read rolls over, 12-bit page wraps at array end
        if (opcode == sfrb_pkg::OP_LP_ARRAY_READ) begin
          page <= page + 12'h001;
        end
      end else begin
        col <= col + 10'h001;
      end
    end else if (byte_done && byte_idx >= sfrb_pkg::FIRST_DATA_IDX && sfrb_pkg::sfrb_is_write(opcode)) begin
      buf_ptr <= (buf_ptr >= last_col) ? 10'h000 : buf_ptr + 10'h001;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic [ARRAY_AW_L-1:0] rd_index;
  logic [7:0] fetch;
  logic [7:0] so_sh;

  assign rd_index = ARRAY_AW_L'(page) * ARRAY_AW_L'(sfrb_pkg::STD_PAGE_BYTES) + ARRAY_AW_L'(col);
  // Array reads fetch straight from main memory and never touch the buffers
  assign fetch = sfrb_pkg::sfrb_is_buf_read(opcode) ? buf_mem[sfrb_pkg::sfrb_buf_sel(opcode)][buf_ptr]
                                                    : main_mem[rd_index];

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      so_sh <= 8'h00;
      LINK.so <= 1'b0;
      LINK.so_oe_n <= 1'b1;
    end else if (!sel) begin
      LINK.so_oe_n <= 1'b1;
    end else if (load_out) begin
      so_sh <= {fetch[6:0], 1'b0};
      LINK.so <= fetch[7];
      LINK.so_oe_n <= 1'b0;
    end else if (sck_fall) begin
      so_sh <= {so_sh[6:0], 1'b0};
      LINK.so <= so_sh[7];
    end
  end

  // ----------------------------------------
  // Program engine
  // ----------------------------------------
  sfrb_pkg::sfrb_pe_t pe_state;
  logic [9:0] pe_cnt;
  logic pe_buf;
  logic [11:0] pe_page;
  logic [ARRAY_AW_L-1:0] pe_index;
  logic pe_last;
  logic prog_start;

  assign pe_index = ARRAY_AW_L'(pe_page) * ARRAY_AW_L'(sfrb_pkg::STD_PAGE_BYTES) + ARRAY_AW_L'(pe_cnt);
  assign pe_last = pe_cnt >= last_col;
  // A program request cut short before its address is complete is dropped
  assign prog_start = cs_rise && sfrb_pkg::sfrb_is_prog(opcode) && byte_idx >= sfrb_pkg::FIRST_DATA_IDX &&
                      pe_state == sfrb_pkg::SFRB_PE_IDLE;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pe_state <= sfrb_pkg::SFRB_PE_IDLE;
      pe_cnt <= 10'h000;
      pe_buf <= 1'b0;
      pe_page <= 12'h000;
    end else begin
      unique case (pe_state)
        sfrb_pkg::SFRB_PE_IDLE: begin
          if (prog_start) begin
            pe_state <= sfrb_pkg::SFRB_PE_ERASE;
            pe_cnt <= 10'h000;
            pe_buf <= sfrb_pkg::sfrb_buf_sel(opcode);
            pe_page <= PAGE_BIN ? addr[20:9] : addr[21:10];
          end
        end
        sfrb_pkg::SFRB_PE_ERASE: begin
          pe_cnt <= pe_last ? 10'h000 : pe_cnt + 10'h001;
          if (pe_last) begin
            pe_state <= sfrb_pkg::SFRB_PE_WRITE;
          end
        end
        sfrb_pkg::SFRB_PE_WRITE: begin
          pe_cnt <= pe_last ? 10'h000 : pe_cnt + 10'h001;
          if (pe_last) begin
            pe_state <= sfrb_pkg::SFRB_PE_VERIFY;
          end
        end
        sfrb_pkg::SFRB_PE_VERIFY: begin
          pe_cnt <= pe_last ? 10'h000 : pe_cnt + 10'h001;
          if (pe_last) begin
            pe_state <= sfrb_pkg::SFRB_PE_IDLE;
          end
        end
      endcase
    end
  end

  // Memories carry no reset; contents are undefined until written
  always_ff @(posedge SYS_CLK) begin
    if (pe_state == sfrb_pkg::SFRB_PE_ERASE) begin
      main_mem[pe_index] <= sfrb_pkg::ERASED_BYTE;
    end else if (pe_state == sfrb_pkg::SFRB_PE_WRITE) begin
      main_mem[pe_index] <= buf_mem[pe_buf][pe_cnt];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (byte_done && byte_idx >= sfrb_pkg::FIRST_DATA_IDX && sfrb_pkg::sfrb_is_write(opcode)) begin
      buf_mem[sfrb_pkg::sfrb_buf_sel(opcode)][buf_ptr] <= next_byte;
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= prog_start || (pe_state != sfrb_pkg::SFRB_PE_IDLE && !(pe_state == sfrb_pkg::SFRB_PE_VERIFY &&
              pe_last));
    end
  end

  // Error holds until the next program starts; a miss read back after writing counts as a failure
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ERASE_PROGRAM_ERROR_FLAG <= 1'b0;
    end else if (pe_state == sfrb_pkg::SFRB_PE_VERIFY && main_mem[pe_index] != buf_mem[pe_buf][pe_cnt]) begin
      ERASE_PROGRAM_ERROR_FLAG <= 1'b1;
    end else if (prog_start) begin
      ERASE_PROGRAM_ERROR_FLAG <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/sfrb_host.sv ====
// Host master end: frames commands on the serial link from a user command port
`timescale 1ns/10ps
`default_nettype none
module sfrb_host (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [23:0] CMD_ADDR,
  input wire logic [9:0] CMD_LEN,
  output logic CMD_READY,
  input wire logic [7:0] WR_DATA,
  output logic WR_TAKE,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  sfrb_link_if.host LINK
);

  // ----------------------------------------
  // Clock divider and input sync
  // ----------------------------------------
  logic [3:0] div;
  logic tick;
  logic so_s1, so_s2;

  assign tick = div == sfrb_pkg::SCK_HALF_CYCLES - 4'h1;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div <= 4'h0;
      so_s1 <= 1'b1;
      so_s2 <= 1'b1;
    end else begin
      div <= tick ? 4'h0 : div + 4'h1;
      so_s1 <= LINK.so_line;
      so_s2 <= so_s1;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  sfrb_pkg::sfrb_host_t state;
  logic [7:0] op;
  logic [23:0] addr;
  logic [11:0] total;
  logic [11:0] byte_n;
  logic [11:0] hdr;
  logic [2:0] bit_n;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [7:0] next_tx;
  logic [11:0] next_n;

  assign hdr = 12'(sfrb_pkg::FIRST_DATA_IDX) + 12'(sfrb_pkg::sfrb_dummy_bytes(op));
  assign next_n = byte_n + 12'h001;

  always_comb begin
    next_tx = 8'h00;
    if (next_n == 12'h001) begin
      next_tx = addr[23:16];
    end else if (next_n == 12'h002) begin
      next_tx = addr[15:8];
    end else if (next_n == 12'h003) begin
      next_tx = addr[7:0];
    end else if (next_n >= 12'(sfrb_pkg::FIRST_DATA_IDX) && sfrb_pkg::sfrb_is_write(op)) begin
      next_tx = WR_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= sfrb_pkg::SFRB_H_IDLE;
      op <= 8'h00;
      addr <= 24'h000000;
      total <= 12'h000;
      byte_n <= 12'h000;
      bit_n <= 3'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      CMD_READY <= 1'b0;
      WR_TAKE <= 1'b0;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      LINK.sck <= 1'b0;
      LINK.cs_n <= 1'b1;
      LINK.si <= 1'b0;
    end else begin
      WR_TAKE <= 1'b0;
      RD_VALID <= 1'b0;
      unique case (state)
        sfrb_pkg::SFRB_H_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY && tick) begin
            CMD_READY <= 1'b0;
            op <= CMD_OPCODE;
            addr <= CMD_ADDR;
            total <= 12'(sfrb_pkg::FIRST_DATA_IDX) + 12'(sfrb_pkg::sfrb_dummy_bytes(CMD_OPCODE)) +
                     12'(CMD_LEN);
            byte_n <= 12'h000;
            bit_n <= 3'h0;
            tx <= {CMD_OPCODE[6:0], 1'b0};
            LINK.si <= CMD_OPCODE[7];
            LINK.cs_n <= 1'b0;
            state <= sfrb_pkg::SFRB_H_SHIFT;
          end
        end
        sfrb_pkg::SFRB_H_SHIFT: begin
          if (tick && !LINK.sck) begin
            LINK.sck <= 1'b1;
            rx <= {rx[6:0], so_s2};
            if (bit_n == 3'h7 && byte_n >= hdr && sfrb_pkg::sfrb_is_read(op)) begin
              RD_DATA <= {rx[6:0], so_s2};
              RD_VALID <= 1'b1;
            end
          end else if (tick) begin
            LINK.sck <= 1'b0;
            bit_n <= bit_n + 3'h1;
            if (bit_n == 3'h7) begin
              byte_n <= next_n;
              if (next_n >= total) begin
                // Select is held low through every byte of the frame and raised only here
                LINK.cs_n <= 1'b1;
                state <= sfrb_pkg::SFRB_H_GAP;
              end else begin
                tx <= {next_tx[6:0], 1'b0};
                LINK.si <= next_tx[7];
                WR_TAKE <= next_n >= 12'(sfrb_pkg::FIRST_DATA_IDX) && sfrb_pkg::sfrb_is_write(op);
              end
            end else begin
              tx <= {tx[6:0], 1'b0};
              LINK.si <= tx[7];
            end
          end
        end
        sfrb_pkg::SFRB_H_GAP: begin
          // One half period high so the device surely sees the select edge
          if (tick) begin
            state <= sfrb_pkg::SFRB_H_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== test/sfrb_link_asserts.sv ====
// Link checker: protocol assertions on the serial link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module sfrb_link_asserts (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic sck_d;
  logic [15:0] rises;
  logic [7:0] op;
  logic [15:0] hdr_bits;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck;
    end
  end

  // Raw pin count; the device lags it by its synchroniser, so counts settle before it answers
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rises <= 16'h0000;
    end else if (cs_n) begin
      rises <= 16'h0000;
    end else if (sck && !sck_d) begin
      rises <= rises + 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op <= 8'h00;
    end else if (!cs_n && sck && !sck_d && rises < 16'h0008) begin
      op <= {op[6:0], si};
    end
  end

  always_comb begin
    case (op)
      8'hD2: hdr_bits = 16'h0040;
      8'hD4, 8'hD6: hdr_bits = 16'h0028;
      default: hdr_bits = 16'h0020;
    endcase
  end

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence high_half;
    sck [*8] ##1 !sck;
  endsequence

  sequence released_soon;
    ##[1:5] so_oe_n;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  so_idle_off_a: assert property (cs_n [*5] |-> so_oe_n) else $error("output driven while deselected");
  read_end_release_a: assert property ($rose(cs_n) |-> released_soon) else $error("output kept after select");
  sck_quiet_a: assert property (cs_n |-> !sck) else $error("link clock moves outside frame");
  cs_byte_end_a: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0) else $error("frame ends mid byte");
  si_hold_a: assert property (sck && $past(sck) |-> $stable(si)) else $error("input changes while clock high");
  so_hold_a: assert property (sck && $past(sck) && !so_oe_n |-> $stable(so))
    else $error("output moves in high half");
  data_start_a: assert property ($fell(so_oe_n) |-> rises == hdr_bits)
    else $error("data starts at wrong bit");
  read_only_drive_a: assert property (!so_oe_n |-> op inside {8'h01, 8'hD2, 8'hD4, 8'hD1, 8'hD6, 8'hD3})
    else $error("output driven by non read command");
  half_period_a: assert property ($rose(sck) |-> high_half) else $error("clock high half wrong length");
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Testbench: host and device ends joined over the link, driven through the host command port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic page_bin = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_opcode = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [9:0] cmd_len = 10'h000;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_take, rd_valid, busy, prog_err;
  logic [7:0] rd_data;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] wq[$];
  logic [7:0] rq[$];

  sfrb_link_if link();
  sfrb_device i_sfrb_device(.SYS_CLK(sys_clk), .ARST_N(arst_n), .PAGE_BIN(page_bin), .BUSY(busy),
    .ERASE_PROGRAM_ERROR_FLAG(prog_err), .LINK(link));
  sfrb_host i_sfrb_host(.SYS_CLK(sys_clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_opcode),
    .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_READY(cmd_ready), .WR_DATA(wr_data), .WR_TAKE(wr_take),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .LINK(link));
  sfrb_link_asserts i_sfrb_link_asserts(.SYS_CLK(sys_clk), .ARST_N(arst_n), .sck(link.sck), .cs_n(link.cs_n),
    .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n));

  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    fail_count++;
    $display("[ERR] %s expected done seen timeout", what);
    report_and_stop();
  endtask

  // Next write byte is only offered after the take pulse, so the host never loads a stale one
  task automatic run_cmd(input logic [7:0] op, input logic [23:0] addr, input logic [9:0] len);
    int n;
    int wi;
    wi = 0;
    rq.delete();
    @(negedge sys_clk);
    for (n = 0; cmd_ready !== 1'b1; n++) begin
      if (n > 100) timeout("ready");
      @(negedge sys_clk);
    end
    cmd_opcode = op;
    cmd_addr = addr;
    cmd_len = len;
    wr_data = wq.size() > 0 ? wq[0] : 8'h00;
    cmd_valid = 1'b1;
    for (n = 0; cmd_ready !== 1'b0; n++) begin
      if (n > 20) timeout("take");
      @(negedge sys_clk);
    end
    cmd_valid = 1'b0;
    for (n = 0; cmd_ready !== 1'b1; n++) begin
      if (n > 20000) timeout("frame");
      @(negedge sys_clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (wr_take === 1'b1 && wi + 1 < wq.size()) begin
        wi++;
        wr_data = wq[wi];
      end
    end
  endtask

  task automatic read_chk(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] e[$]);
    run_cmd(op, addr, 10'(e.size()));
    chk("read count", 8'(rq.size()), 8'(e.size()));
    foreach (e[i]) chk($sformatf("read %h byte %0d", op, i), rq[i], e[i]);
    chk("released line", {7'h00, link.so_line}, 8'h01);
  endtask

  task automatic write_buf(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] d[$]);
    wq = d;
    run_cmd(op, addr, 10'(d.size()));
    wq.delete();
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] addr);
    int n;
    run_cmd(op, addr, 10'h000);
    for (n = 0; busy !== 1'b1; n++) begin
      if (n > 40) timeout("busy rise");
      @(negedge sys_clk);
    end
    for (n = 0; busy !== 1'b0; n++) begin
      if (n > 3000) timeout("busy fall");
      @(negedge sys_clk);
    end
    chk("error flag", {7'h00, prog_err}, 8'h00);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_buffers();
    write_buf(8'h84, 24'hFFFE0E, '{8'hA1, 8'hB2, 8'hC3});
    write_buf(8'h87, 24'h000000, '{8'h5A, 8'h6B});
    read_chk(8'hD4, 24'hFFFE0E, '{8'hA1, 8'hB2, 8'hC3});
    read_chk(8'hD1, 24'h00020F, '{8'hB2, 8'hC3});
    read_chk(8'hD6, 24'h000000, '{8'h5A, 8'h6B});
    read_chk(8'hD3, 24'h000001, '{8'h6B});
  endtask

  task automatic t_program();
    prog(8'h83, 24'h3FFC00);
    prog(8'h86, 24'h000000);
  endtask

  // Last page end rolls into page zero, so one read covers both the page and array crossings
  task automatic t_array();
    read_chk(8'hD2, 24'h3FFE0F, '{8'hB2, 8'hC3});
    read_chk(8'h01, 24'h3FFE0F, '{8'hB2, 8'h5A, 8'h6B});
  endtask

  task automatic t_kept();
    read_chk(8'hD1, 24'h00020E, '{8'hA1, 8'hB2, 8'hC3});
    read_chk(8'hD3, 24'h000000, '{8'h5A, 8'h6B});
  endtask

  task automatic t_bin();
    @(negedge sys_clk);
    page_bin = 1'b1;
    read_chk(8'hD2, 24'h1FFE00, '{8'hC3});
    write_buf(8'h84, 24'hFFFFFF, '{8'h11, 8'h22});
    read_chk(8'hD4, 24'hFFFFFF, '{8'h11, 8'h22});
    page_bin = 1'b0;
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    t_buffers();
    t_program();
    t_array();
    t_kept();
    t_bin();
    report_and_stop();
  end
endmodule
`default_nettype wire
